// file: src/dcw_regs.vh
// register offsets, field positions and fixed values of the device capability word
`ifndef DCW_REGS_VH
`define DCW_REGS_VH

`define DCW_OFF_DEVCAP      12'h004
`define DCW_OFF_TAGSTAT     12'h008

`define DCW_RSVD_HI_MSB     31
`define DCW_RSVD_HI_LSB     29
`define DCW_FLR_BIT         28
`define DCW_SPL_SCALE_MSB   27
`define DCW_SPL_SCALE_LSB   26
`define DCW_SPL_VALUE_MSB   25
`define DCW_SPL_VALUE_LSB   18
`define DCW_RSVD_LO_MSB     17
`define DCW_RSVD_LO_LSB     16
`define DCW_RBER_BIT        15
`define DCW_PWR_IND_BIT     14
`define DCW_ATT_IND_BIT     13
`define DCW_ATT_BTN_BIT     12
`define DCW_L1_LAT_MSB      11
`define DCW_L1_LAT_LSB      9
`define DCW_L0S_LAT_MSB     8
`define DCW_L0S_LAT_LSB     6
`define DCW_EXT_TAG_BIT     5
`define DCW_PHANTOM_MSB     4
`define DCW_PHANTOM_LSB     3
`define DCW_MPS_MSB         2
`define DCW_MPS_LSB         0

`define DCW_RBER_VAL        1'h1
`define DCW_PWR_IND_VAL     1'h0
`define DCW_ATT_IND_VAL     1'h0
`define DCW_ATT_BTN_VAL     1'h0
`define DCW_L1_LAT_VAL      3'h4
`define DCW_L0S_LAT_VAL     3'h4
`define DCW_EXT_TAG_VAL     1'h0
`define DCW_PHANTOM_VAL     2'h0
`define DCW_MPS_VAL         3'h2

`define DCW_SPL_SCALE_RST   2'h0
`define DCW_SPL_VALUE_RST   8'h00

`define DCW_TAG_W           5
`define DCW_TAG_COUNT       32
`define DCW_CNT_W           6

`endif

// file: src/dcw_top.v
// device capability word register with APB access and requester tag pool
//
// Overview of operation
// - two-bit slot power scale at 27:26
// - eight-bit slot power value at 25:18
// - bit 15 reads one, role-based errors
// - bits 14:12 read zero, no indicators
// - L1 acceptable latency field reads 100b
// - L0s acceptable latency field reads 100b
// - bit 5 zero, tags from 32 values
// - at most 32 requests outstanding
// - phantom function field reads 00b
// - max payload supported field reads 010b
`timescale 1ns/100ps
`default_nettype none
`include "dcw_regs.vh"

module dcw_top #(
  parameter       ADDR_W  = 12,
  parameter [0:0] FLR_CAP = 1'h0
) (
  input  wire              mclk,
  input  wire              reset_n,
  input  wire              ce,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output wire              pready,
  output wire [31:0]       prdata,
  output wire              pslverr,
  input  wire              spl_msg_valid,
  input  wire [1:0]        spl_msg_scale,
  input  wire [7:0]        spl_msg_value,
  input  wire              tag_req_valid,
  output wire              tag_req_ready,
  output wire [4:0]        tag_req_tag,
  input  wire              tag_cpl_valid,
  input  wire [4:0]        tag_cpl_tag,
  output wire [5:0]        tag_outstanding
);

  wire [1:0]  spl_scale_reg;
  wire [7:0]  spl_value_reg;
  reg         pready_reg;
  reg  [31:0] prdata_reg;
  reg         pslverr_reg;
  wire [31:0] busy_reg;
  wire [31:0] busy_next;
  reg  [5:0]  count_reg;
  reg  [5:0]  count_next;
  reg  [4:0]  tag_reg;
  reg         avail_reg;
  reg  [31:0] devcap_word;
  reg  [31:0] tagstat_word;
  reg  [31:0] read_word;
  reg         read_hit;

  wire        access   = psel & penable;
  wire        commit   = access & pready_reg;
  wire        wr_cap   = commit & pwrite & (paddr == `DCW_OFF_DEVCAP);
  wire        grant    = tag_req_valid & avail_reg & ce;
  wire        cpl_hit  = tag_cpl_valid & busy_reg[tag_cpl_tag];
  wire [31:0] take_vec = {31'h00000000, grant} << tag_reg;
  wire [31:0] drop_vec = {31'h00000000, cpl_hit} << tag_cpl_tag;
  // only bytes 3 and 2 can write, and only where a field takes the bits
  wire [31:0] wr_bits  = {{8{pstrb[3]}}, {8{pstrb[2]}}, 16'h0000} & {32{wr_cap}};

  // lowest free tag of a busy mask; all-busy returns zero and is masked by avail
  function [4:0] first_free;
    input [31:0] busy;
    integer i;
    begin
      first_free = 5'h00;
      for (i = `DCW_TAG_COUNT - 1; i >= 0; i = i - 1) begin
        if (!busy[i]) begin
          first_free = i[4:0];
        end
      end
    end
  endfunction

  // composed word; constant fields are wired so no write path exists to them
  always @* begin
    devcap_word = 32'h00000000;
    devcap_word[`DCW_FLR_BIT] = FLR_CAP;
    devcap_word[`DCW_SPL_SCALE_MSB:`DCW_SPL_SCALE_LSB] = spl_scale_reg;
    devcap_word[`DCW_SPL_VALUE_MSB:`DCW_SPL_VALUE_LSB] = spl_value_reg;
    devcap_word[`DCW_RBER_BIT] = `DCW_RBER_VAL;
    devcap_word[`DCW_PWR_IND_BIT] = `DCW_PWR_IND_VAL;
    devcap_word[`DCW_ATT_IND_BIT] = `DCW_ATT_IND_VAL;
    devcap_word[`DCW_ATT_BTN_BIT] = `DCW_ATT_BTN_VAL;
    devcap_word[`DCW_L1_LAT_MSB:`DCW_L1_LAT_LSB] = `DCW_L1_LAT_VAL;
    devcap_word[`DCW_L0S_LAT_MSB:`DCW_L0S_LAT_LSB] = `DCW_L0S_LAT_VAL;
    devcap_word[`DCW_EXT_TAG_BIT] = `DCW_EXT_TAG_VAL;
    devcap_word[`DCW_PHANTOM_MSB:`DCW_PHANTOM_LSB] = `DCW_PHANTOM_VAL;
    devcap_word[`DCW_MPS_MSB:`DCW_MPS_LSB] = `DCW_MPS_VAL;
  end

  always @* begin
    tagstat_word = 32'h00000000;
    tagstat_word[5:0] = count_reg;
    tagstat_word[8] = ~avail_reg;
  end

  always @* begin
    read_word = 32'h00000000;
    read_hit  = 1'b1;
    case (paddr)
      `DCW_OFF_DEVCAP: begin
        read_word = devcap_word;
      end
      `DCW_OFF_TAGSTAT: begin
        read_word = tagstat_word;
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  // slot power fields: a captured limit message beats a software write
  dcw_cap_field #(
    .W   (2),
    .RST (`DCW_SPL_SCALE_RST)
  ) u_spl_scale (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .ce       (ce),
    .wr_en    (wr_bits[`DCW_SPL_SCALE_MSB:`DCW_SPL_SCALE_LSB]),
    .wr_data  (pwdata[`DCW_SPL_SCALE_MSB:`DCW_SPL_SCALE_LSB]),
    .cap_en   (spl_msg_valid),
    .cap_data (spl_msg_scale),
    .value    (spl_scale_reg)
  );

  dcw_cap_field #(
    .W   (8),
    .RST (`DCW_SPL_VALUE_RST)
  ) u_spl_value (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .ce       (ce),
    .wr_en    (wr_bits[`DCW_SPL_VALUE_MSB:`DCW_SPL_VALUE_LSB]),
    .wr_data  (pwdata[`DCW_SPL_VALUE_MSB:`DCW_SPL_VALUE_LSB]),
    .cap_en   (spl_msg_valid),
    .cap_data (spl_msg_value),
    .value    (spl_value_reg)
  );

  // tag pool: a tag is handed out only while free, so 32 is the ceiling
  always @* begin
    count_next = count_reg;
    case ({grant, cpl_hit})
      2'b10: begin
        count_next = count_reg + 6'h01;
      end
      2'b01: begin
        count_next = count_reg - 6'h01;
      end
      default: begin
        count_next = count_reg;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < `DCW_TAG_COUNT; g = g + 1) begin : g_slot
      dcw_tag_slot #(
        .RST (1'h0)
      ) u_slot (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .ce        (ce),
        .take      (take_vec[g]),
        .drop      (drop_vec[g]),
        .busy_next (busy_next[g]),
        .busy      (busy_reg[g])
      );
    end
  endgenerate

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg    <= 1'b0;
      prdata_reg    <= 32'h00000000;
      pslverr_reg   <= 1'b0;
    end else if (ce) begin
      // one wait state lets read data come straight from a flop
      pready_reg    <= access & ~pready_reg;
      if (access & ~pready_reg) begin
        prdata_reg  <= pwrite ? 32'h00000000 : read_word;
        pslverr_reg <= ~read_hit;
      end else begin
        prdata_reg  <= 32'h00000000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 6'h00;
      tag_reg   <= 5'h00;
      avail_reg <= 1'b1;
    end else if (ce) begin
      count_reg <= count_next;
      tag_reg   <= first_free(busy_next);
      avail_reg <= ~(&busy_next);
    end
  end

  assign pready          = pready_reg & ce;
  assign prdata          = prdata_reg;
  assign pslverr         = pslverr_reg & pready_reg & ce;
  assign tag_req_ready   = avail_reg & ce;
  assign tag_req_tag     = tag_reg;
  assign tag_outstanding = count_reg;

endmodule // dcw_top

// one captured field: software writes per bit, a captured message overrides
module dcw_cap_field #(
  parameter         W   = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         mclk,
  input  wire         reset_n,
  input  wire         ce,
  input  wire [W-1:0] wr_en,
  input  wire [W-1:0] wr_data,
  input  wire         cap_en,
  input  wire [W-1:0] cap_data,
  output wire [W-1:0] value
);
  reg [W-1:0] field_reg;
  reg [W-1:0] field_next;

  always @* begin
    field_next = (field_reg & ~wr_en) | (wr_data & wr_en);
    if (cap_en) begin
      field_next = cap_data;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      field_reg <= RST;
    end else if (ce) begin
      field_reg <= field_next;
    end
  end

  assign value = field_reg;
endmodule // dcw_cap_field

// one tag of the pool: busy from its grant until its completion
module dcw_tag_slot #(
  parameter [0:0] RST = 1'h0
) (
  input  wire mclk,
  input  wire reset_n,
  input  wire ce,
  input  wire take,
  input  wire drop,
  output wire busy_next,
  output wire busy
);
  reg slot_reg;
  reg slot_next;

  // a grant wins over a completion of the same slot
  always @* begin
    slot_next = slot_reg;
    if (drop) begin
      slot_next = 1'b0;
    end
    if (take) begin
      slot_next = 1'b1;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slot_reg <= RST;
    end else if (ce) begin
      slot_reg <= slot_next;
    end
  end

  assign busy_next = slot_next;
  assign busy      = slot_reg;
endmodule // dcw_tag_slot

`default_nettype wire

// file: testbench/dcw_chk_assertions.sv
// assertions on the ports of the device capability word block
`timescale 1ns/100ps
`default_nettype none
module dcw_chk (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tag_req_valid,
  input wire logic        tag_req_ready,
  input wire logic        tag_cpl_valid,
  input wire logic [5:0]  tag_outstanding
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire rd_cap = pready && !pwrite && paddr == 12'h004;
  property p_fix; rd_cap |-> prdata[15:0] == 16'h8902; endproperty
  a_fix: assert property (p_fix) else $error("fixed fields wrong");
  property p_rsv; rd_cap |-> prdata[31:29] == 3'h0 && prdata[17:16] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_flr; rd_cap |-> prdata[28] == 1'h0; endproperty
  a_flr: assert property (p_flr) else $error("reset capability bit wrong");
  property p_bad; pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped access answered");
  property p_max; tag_outstanding <= 6'd32; endproperty
  a_max: assert property (p_max) else $error("too many outstanding");
  property p_full; tag_outstanding == 6'd32 |-> !tag_req_ready; endproperty
  a_full: assert property (p_full) else $error("grant offered while full");
  property p_inc; tag_req_valid && tag_req_ready && !tag_cpl_valid |=>
    tag_outstanding == $past(tag_outstanding) + 6'd1; endproperty
  a_inc: assert property (p_inc) else $error("grant not counted");
  property p_room; ce && tag_outstanding < 6'd32 |-> tag_req_ready; endproperty
  a_room: assert property (p_room) else $error("free tag withheld");
endmodule // dcw_chk
bind dcw_top dcw_chk u_chk (.*);
`default_nettype wire

// file: testbench/dcw_rc_model.sv
// apb requester standing in for the configuration path of the root complex
`timescale 1ns/100ps
`default_nettype none
module dcw_rc_model (
  input  wire logic        mclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  logic [31:0] rd_data;
  logic        rd_err;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // enter just after a rising edge; no latency assumed, bench timeout ends a hang
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    // idle edge so a following call never drives psel twice in one step
    @(posedge mclk);
  endtask
endmodule // dcw_rc_model
`default_nettype wire

// file: testbench/dcw_top_test.sv
// self-checking bench for the device capability word block
`timescale 1ns/100ps
`default_nettype none
module dcw_top_test;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, tag_req_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        spl_msg_valid = 1'b0;
  logic [1:0]  spl_msg_scale = 2'h0;
  logic [7:0]  spl_msg_value = 8'h00;
  logic        tag_req_valid = 1'b0;
  logic        tag_cpl_valid = 1'b0;
  logic [4:0]  tag_cpl_tag = 5'h00;
  logic [4:0]  tag_req_tag;
  logic [5:0]  tag_outstanding;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #25 mclk = ~mclk;
  dcw_top dut (.*, .pstrb(4'hF));
  dcw_rc_model rc (.*);
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    rc.xfer(1'b0, a, 32'h0);
    chk("read data", exp, rc.rd_data);
    chk("error flag", {31'h0, err}, {31'h0, rc.rd_err});
  endtask
  task t_power;
    for (logic [7:0] s = 0; s < 4; s++) begin
      // ones into every read-only bit must not stick
      rc.xfer(1'b1, 12'h004, {4'hF, s[1:0], 8'hA5 ^ s, 18'h3FFFF});
      rd(12'h004, {4'h0, s[1:0], 8'hA5 ^ s, 18'h08902}, 1'b0);
    end
    spl_msg_valid <= 1'b1;
    spl_msg_scale <= 2'h1;
    spl_msg_value <= 8'h3C;
    @(posedge mclk);
    spl_msg_valid <= 1'b0;
    rd(12'h004, {4'h0, 2'h1, 8'h3C, 18'h08902}, 1'b0);
    $display("t_power done");
  endtask
  task t_tags;
    tag_req_valid <= 1'b1;
    repeat (34) @(posedge mclk);
    tag_req_valid <= 1'b0;
    @(posedge mclk);
    chk("outstanding", 32'd32, {26'h0, tag_outstanding});
    chk("ready when full", 32'h0, {31'h0, tag_req_ready});
    rd(12'h008, 32'h00000120, 1'b0);
    tag_cpl_valid <= 1'b1;
    tag_cpl_tag <= 5'h05;
    @(posedge mclk);
    tag_cpl_valid <= 1'b0;
    @(posedge mclk);
    chk("outstanding", 32'd31, {26'h0, tag_outstanding});
    chk("freed tag", 32'h5, {27'h0, tag_req_tag});
    $display("t_tags done");
  endtask
  task t_hold;
    ce <= 1'b0;
    tag_req_valid <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("frozen count", 32'd31, {26'h0, tag_outstanding});
    chk("ready while frozen", 32'h0, {31'h0, tag_req_ready});
    tag_req_valid <= 1'b0;
    ce <= 1'b1;
    @(posedge mclk);
    tag_req_valid <= 1'b1;
    @(posedge mclk);
    tag_req_valid <= 1'b0;
    @(posedge mclk);
    chk("count after thaw", 32'd32, {26'h0, tag_outstanding});
    $display("t_hold done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(12'h004, 32'h00008902, 1'b0);
    rd(12'h00C, 32'h0, 1'b1);
    $display("t_reset done");
    t_power;
    t_tags;
    t_hold;
    complete_run;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      complete_run;
    end
  end
endmodule // dcw_top_test
`default_nettype wire
